//--- rtl/wdt_core.sv
/*
 * Two-stage watchdog with byte register port, lock register and expiry pin.
 * Assumes a host issuing single-cycle byte reads/writes on REF_CLK.
 */
`timescale 1ns/1ps
`include "wdt_cfg.svh"

// Notes on behaviour
// [R1] Counter bits 15:8 and 19:16 of the upper twenty readable; top nibble reserved.
// [R2] Counter view reads are indeterminate; software treats them as reserved.
// [R3] Counter decrements every enabled clock while running.
// [R4] Each new stage loads its preload value into the counter.
// [R5] Run-enable rising loads preload one and starts counting.
// [R6] By default expiry output goes high once and stays until reset.
// [R7] Run-enable is lock bit 1; ignored while the freeze bit is set.
// [R8] Preload one reloads on enable rise or unlocked kick write.
// [R9] A timeout requests a reset.
// [R10] Software kicks before disabling so no timeout is imminent.
// [R11] Freeze bit 0 set once locks register until hard reset.
// [R12] Second consecutive zero without kick sets flag and drives output high.
// [R13] Repeat select bit 2 toggles output on each later timeout.
// [R14] Kick, flag and preload writes accepted only after unlocking.
// [R15] Unlock is byte 80 then 86 written to offset 0Ch.
// [R16] Any other write abandons a partial unlock sequence.
// [R17] Unlock accesses must be single-byte cycles.
// [R18] Guarded registers relock after one write.
// [R19] Software kicks periodically: unlock then write 1 to bit 8.
// [R20] All activity halts while the bus clock is stopped.
// [R21] Prescale 0 loads preload into bits 34:15, 1 into bits 24:5.
// [R22] Expiry flag survives host reset; cleared by unlocked write of 1.
// [R23] Software programs each preload as period minus one.
// [R24] First stage expiry loads preload two for a second stage.
module wdt_core #(
	parameter int CNT_WIDTH = `CNT_W,
	parameter int PRE_WIDTH = `PRE_W
) (
	input wire logic REF_CLK,
	input wire logic NRST,
	input wire logic NRST_RTC,
	input wire logic CE,
	input wire logic WR,
	input wire logic RD,
	input wire logic BYTE_ACCESS,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	output logic [7:0] RDATA,
	output logic RVALID,
	output logic EXPIRY_OUTPUT,
	output logic RESET_REQ,
	output wdt_pkg::stage_t STAGE
);
	import wdt_pkg::*;

	logic [PRE_WIDTH-1:0] preload1_q;
	logic [PRE_WIDTH-1:0] preload2_q;
	logic [7:0] lock_q;
	logic [7:0] config_q;
	logic [CNT_WIDTH-1:0] count_q;
	logic expiry_flag_q;
	logic expiry_output_q;
	logic reset_req_q;
	logic [7:0] rdata_q;
	logic rvalid_q;
	stage_t stage_q;
	logic open;
	logic wr_en;
	logic guarded_wr;
	logic kick;
	logic run_rise;
	logic run_d;
	logic at_zero;
	logic [CNT_WIDTH-1:0] load1;
	logic [CNT_WIDTH-1:0] load2;

	// ----------------------------------------------------------------------
	// Unlock sequencer
	// ----------------------------------------------------------------------
	wdt_unlock u_unlock (
		.clk(REF_CLK),
		.rst_n(NRST),
		.ce(CE),
		.wr(WR),
		.byte_access(BYTE_ACCESS),
		.addr(ADDR),
		.wdata(WDATA),
		.open_q(open)
	);

	// Nothing moves while the clock enable is low
	assign wr_en = CE && WR; // see [R20]
	assign guarded_wr = wr_en && open; // see [R14]
	assign kick = guarded_wr && ADDR == `OFS_RELOAD_HI && WDATA[`BIT_KICK];

	// ----------------------------------------------------------------------
	// Preload registers
	// ----------------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			preload1_q <= PRE_WIDTH'(`RST_PRELOAD);
			preload2_q <= PRE_WIDTH'(`RST_PRELOAD);
		end else if (guarded_wr) begin
			unique case (ADDR)
				`OFS_PRELOAD1_B0: preload1_q[7:0] <= WDATA;
				`OFS_PRELOAD1_B1: preload1_q[15:8] <= WDATA;
				`OFS_PRELOAD1_B2: preload1_q[19:16] <= WDATA[3:0];
				`OFS_PRELOAD2_B0: preload2_q[7:0] <= WDATA;
				`OFS_PRELOAD2_B1: preload2_q[15:8] <= WDATA;
				`OFS_PRELOAD2_B2: preload2_q[19:16] <= WDATA[3:0];
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------------
	// Configuration and lock registers
	// ----------------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			config_q <= `RST_CONFIG;
		end else if (wr_en && ADDR == `OFS_CONFIG) begin
			config_q <= {2'h0, WDATA[5:0]};
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			lock_q <= `RST_LOCK;
		end else if (wr_en && ADDR == `OFS_LOCK_CTRL && !lock_q[`BIT_FREEZE]) begin
			// Freeze bit only ever goes 0 to 1
			lock_q[`BIT_REPEAT] <= WDATA[`BIT_REPEAT];
			lock_q[`BIT_RUN] <= WDATA[`BIT_RUN]; // see [R7]
			lock_q[`BIT_FREEZE] <= WDATA[`BIT_FREEZE]; // see [R11]
		end
	end

	assign run_d = lock_q[`BIT_RUN];

	// ----------------------------------------------------------------------
	// Down counter and stages
	// ----------------------------------------------------------------------
	logic run_prev_q;
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			run_prev_q <= 1'b0;
		end else if (CE) begin
			run_prev_q <= run_d;
		end
	end
	assign run_rise = run_d && !run_prev_q;

	// Preload justified by prescale choice
	assign load1 = config_q[`BIT_PRESCALE] ?
		(CNT_WIDTH'(preload1_q) << `SHIFT_FAST) :
		(CNT_WIDTH'(preload1_q) << `SHIFT_SLOW); // see [R21]
	assign load2 = config_q[`BIT_PRESCALE] ?
		(CNT_WIDTH'(preload2_q) << `SHIFT_FAST) :
		(CNT_WIDTH'(preload2_q) << `SHIFT_SLOW); // see [R21]
	assign at_zero = (count_q == '0);

	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			stage_q <= ST_IDLE;
			count_q <= '0;
		end else if (CE) begin
			if (!run_d) begin
				stage_q <= ST_IDLE;
			end else if (run_rise || kick) begin
				stage_q <= ST_STAGE1; // see [R5] see [R8]
				count_q <= load1; // see [R4]
			end else begin
				unique case (stage_q)
					ST_IDLE: begin
						stage_q <= ST_STAGE1;
						count_q <= load1;
					end
					ST_STAGE1: begin
						if (at_zero) begin
							stage_q <= ST_STAGE2; // see [R24]
							count_q <= load2; // see [R4]
						end else begin
							count_q <= count_q - 1'b1; // see [R3]
						end
					end
					ST_STAGE2: begin
						if (at_zero) begin
							// Timeout; start over so repeat mode sees later ones
							stage_q <= ST_STAGE1;
							count_q <= load1;
						end else begin
							count_q <= count_q - 1'b1; // see [R3]
						end
					end
					default: begin
						stage_q <= ST_IDLE;
					end
				endcase
			end
		end
	end

	logic timeout;
	assign timeout = CE && run_d && !run_rise && !kick && stage_q == ST_STAGE2 && at_zero;

	// ----------------------------------------------------------------------
	// Expiry flag, kept on the always-on reset
	// ----------------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (!NRST_RTC) begin
			expiry_flag_q <= 1'b0;
		end else if (timeout) begin
			expiry_flag_q <= 1'b1; // see [R12]
		end else if (guarded_wr && ADDR == `OFS_RELOAD_HI && WDATA[`BIT_EXPIRY]) begin
			expiry_flag_q <= 1'b0; // see [R22]
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			expiry_output_q <= 1'b0;
		end else if (timeout && !config_q[`BIT_OUT_DISABLE]) begin
			if (!expiry_output_q) begin
				expiry_output_q <= 1'b1; // see [R6] see [R12]
			end else if (lock_q[`BIT_REPEAT]) begin
				expiry_output_q <= 1'b0; // see [R13]
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			reset_req_q <= 1'b0;
		end else if (CE) begin
			reset_req_q <= timeout; // see [R9]
		end
	end

	// ----------------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------------
	// Counter views are a snapshot with no coherence across bytes
	logic [PRE_WIDTH-1:0] upper;
	assign upper = count_q[CNT_WIDTH-1 -: PRE_WIDTH];

	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
		end else if (CE) begin
			rvalid_q <= RD;
			if (RD) begin
				unique case (ADDR)
					`OFS_PRELOAD1_B0: rdata_q <= preload1_q[7:0];
					`OFS_PRELOAD1_B1: rdata_q <= preload1_q[15:8];
					`OFS_PRELOAD1_B2: rdata_q <= {4'h0, preload1_q[19:16]};
					`OFS_PRELOAD2_B0: rdata_q <= preload2_q[7:0];
					`OFS_PRELOAD2_B1: rdata_q <= preload2_q[15:8];
					`OFS_PRELOAD2_B2: rdata_q <= {4'h0, preload2_q[19:16]};
					`OFS_RELOAD_HI: rdata_q <= {6'h00, expiry_flag_q, 1'b0};
					`OFS_CONFIG: rdata_q <= config_q;
					`OFS_VIEW_LOW: rdata_q <= upper[7:0]; // see [R2]
					`OFS_VIEW_MID: rdata_q <= upper[15:8]; // see [R1] see [R2]
					`OFS_VIEW_TOP: rdata_q <= {4'h0, upper[19:16]}; // see [R1]
					`OFS_LOCK_CTRL: rdata_q <= lock_q;
					default: rdata_q <= 8'h00;
				endcase
			end
		end
	end

	assign RDATA = rdata_q;
	assign RVALID = rvalid_q;
	assign EXPIRY_OUTPUT = expiry_output_q;
	assign RESET_REQ = reset_req_q;
	assign STAGE = stage_q;
endmodule // wdt_core

//--- rtl/wdt_cfg.svh
/*
 * Offsets, field positions, reset values and timing counts of the watchdog.
 * Assumes an 8-bit byte-wide register port decoded on the low address bits.
 */
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_PRELOAD1_B0 8'h00
`define OFS_PRELOAD1_B1 8'h01
`define OFS_PRELOAD1_B2 8'h02
`define OFS_PRELOAD2_B0 8'h04
`define OFS_PRELOAD2_B1 8'h05
`define OFS_PRELOAD2_B2 8'h06
`define OFS_RELOAD_LO 8'h0C
`define OFS_RELOAD_HI 8'h0D
`define OFS_CONFIG 8'h10
`define OFS_VIEW_LOW 8'h14
`define OFS_VIEW_MID 8'h15
`define OFS_VIEW_TOP 8'h16
`define OFS_LOCK_CTRL 8'h18

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_FREEZE 0
`define BIT_RUN 1
`define BIT_REPEAT 2
`define BIT_KICK 0
`define BIT_EXPIRY 1
`define BIT_PRESCALE 2
`define BIT_OUT_DISABLE 5

// ----------------------------------------------------------------------
// Keys, reset values and counts
// ----------------------------------------------------------------------
`define KEY_FIRST 8'h80
`define KEY_SECOND 8'h86
`define RST_PRELOAD 20'hFFFFF
`define RST_LOCK 8'h00
`define RST_CONFIG 8'h00
`define CNT_W 35
`define PRE_W 20
`define SHIFT_SLOW 15
`define SHIFT_FAST 5

`endif

//--- rtl/wdt_pkg.sv
/*
 * Types shared by the watchdog files.
 * Assumes the constants header is included alongside.
 */
package wdt_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_STAGE1 = 3'b010,
		ST_STAGE2 = 3'b100
	} stage_t;

	typedef enum logic [2:0] {
		UK_NONE = 3'b001,
		UK_FIRST = 3'b010,
		UK_OPEN = 3'b100
	} unlock_t;
endpackage

//--- rtl/wdt_unlock.sv
/*
 * Two-key unlocking sequencer guarding writes to protected registers.
 * Assumes byte-wide write strobes, one cycle each, synchronous to REF_CLK.
 */
`timescale 1ns/1ps
`include "wdt_cfg.svh"

module wdt_unlock (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic wr,
	input wire logic byte_access,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	output logic open_q
);
	import wdt_pkg::*;

	unlock_t state_q;

	assign open_q = (state_q == UK_OPEN);

	// ----------------------------------------------------------------------
	// Key sequence
	// ----------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= UK_NONE;
		end else if (ce && wr) begin
			// Any write moves the sequence; wrong keys restart it
			unique case (state_q)
				UK_NONE: begin
					if (byte_access && addr == `OFS_RELOAD_LO && wdata == `KEY_FIRST) begin
						state_q <= UK_FIRST;
					end
				end
				UK_FIRST: begin
					if (byte_access && addr == `OFS_RELOAD_LO && wdata == `KEY_SECOND) begin
						state_q <= UK_OPEN; // see [R15]
					end else begin
						state_q <= UK_NONE; // see [R16] see [R17]
					end
				end
				UK_OPEN: begin
					state_q <= UK_NONE; // see [R18]
				end
				default: begin
					state_q <= UK_NONE;
				end
			endcase
		end
	end
endmodule // wdt_unlock

//--- test/wdt_core_asserts.sv
/* Port assertions for the watchdog core.
   Assumes one clock REF_CLK and synchronous active-low reset NRST. */
`timescale 1ns/1ps
module wdt_core_asserts #(
	parameter int CNT_WIDTH = 35,
	parameter int PRE_WIDTH = 20
) (
	input wire logic REF_CLK,
	input wire logic NRST,
	input wire logic NRST_RTC,
	input wire logic CE,
	input wire logic WR,
	input wire logic RD,
	input wire logic BYTE_ACCESS,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic [7:0] RDATA,
	input wire logic RVALID,
	input wire logic EXPIRY_OUTPUT,
	input wire logic RESET_REQ,
	input wire wdt_pkg::stage_t STAGE
);
	import wdt_pkg::*;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!NRST);
	a_read_answer: assert property (RD && CE |=> RVALID)
		else $error("read not answered");
	a_answer_cause: assert property (RVALID |-> $past(RD))
		else $error("answer without read");
	a_req_pulse: assert property (RESET_REQ && CE |=> !RESET_REQ)
		else $error("reset request too long");
	a_req_cause: assert property ($rose(RESET_REQ) |->
		$past(STAGE) == ST_STAGE2 || $past(STAGE, 2) == ST_STAGE2)
		else $error("reset request outside second stage");
	a_pin_timeout: assert property ($changed(EXPIRY_OUTPUT) |-> ##[0:2] RESET_REQ)
		else $error("pin moved without timeout");
	a_stage_onehot: assert property ($onehot(STAGE))
		else $error("stage not one-hot");
	a_freeze_hold: assert property (!CE |=> $stable(STAGE) && $stable(EXPIRY_OUTPUT))
		else $error("activity while clock stopped");
	a_idle_exit: assert property (STAGE == ST_IDLE |=> STAGE inside {ST_IDLE, ST_STAGE1})
		else $error("idle left to wrong stage");
	a_stage2_entry: assert property ($changed(STAGE) && STAGE == ST_STAGE2 |->
		$past(STAGE) == ST_STAGE1)
		else $error("second stage not after first");
	c_run: cover property (STAGE == ST_STAGE1);
	c_stage2: cover property (STAGE == ST_STAGE2);
	c_timeout: cover property (RESET_REQ);
endmodule // wdt_core_asserts

bind wdt_core wdt_core_asserts #(.CNT_WIDTH(CNT_WIDTH), .PRE_WIDTH(PRE_WIDTH)) chk_u (
	.REF_CLK(REF_CLK), .NRST(NRST), .NRST_RTC(NRST_RTC), .CE(CE), .WR(WR), .RD(RD),
	.BYTE_ACCESS(BYTE_ACCESS), .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA), .RVALID(RVALID),
	.EXPIRY_OUTPUT(EXPIRY_OUTPUT), .RESET_REQ(RESET_REQ), .STAGE(STAGE));

//--- test/test_wdt_core.sv
/* Self-checking bench for the watchdog core.
   Assumes the byte register port and stage types of wdt_pkg. */
`timescale 1ns/1ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
	$display("unexpected %s exp %h got %h", n, e, a); end end
module test_wdt_core;
	import wdt_pkg::*;
	logic clk, nrst, nrst_rtc, ce, wr_en, rd_en, byte_acc, rvalid, expiry, reset_req;
	logic seen2, seenr;
	logic [7:0] addr, wdata, rdata, d;
	stage_t stage, st;
	int mismatches, cmp_count;
	logic [7:0] tw[4] = '{8'h04, 8'h00, 8'h02, 8'h00};
	stage_t ts[4] = '{ST_IDLE, ST_IDLE, ST_STAGE1, ST_IDLE};
	logic [7:0] pa[6] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h06};
	logic [7:0] pv[6] = '{8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};

	wdt_core dut_u (.REF_CLK(clk), .NRST(nrst), .NRST_RTC(nrst_rtc), .CE(ce), .WR(wr_en),
		.RD(rd_en), .BYTE_ACCESS(byte_acc), .ADDR(addr), .WDATA(wdata), .RDATA(rdata),
		.RVALID(rvalid), .EXPIRY_OUTPUT(expiry), .RESET_REQ(reset_req), .STAGE(stage));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	always @(posedge clk) begin
		if (stage === ST_STAGE2) seen2 <= 1'b1;
		if (reset_req === 1'b1) seenr <= 1'b1;
	end

	task automatic put(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		#1;
		addr = a;
		wdata = v;
		wr_en = 1'b1;
		@(posedge clk);
		#1;
		wr_en = 1'b0;
	endtask

	task automatic get(input logic [7:0] a);
		@(posedge clk);
		#1;
		addr = a;
		rd_en = 1'b1;
		@(posedge clk);
		#1;
		rd_en = 1'b0;
		`CHK("rvalid", 1'b1, rvalid)
		d = rdata;
	endtask

	task automatic unlock(input logic [7:0] a, input logic [7:0] v);
		put(8'h0C, 8'h80);
		put(8'h0C, 8'h86);
		put(a, v);
	endtask

	// Broken kicks: stray write, wide keys, or keys spent on another write
	task automatic bad_kick(input int j);
		byte_acc = (j != 1);
		put(8'h0C, 8'h80);
		if (j == 0) put(8'h10, 8'h04);
		put(8'h0C, 8'h86);
		byte_acc = 1'b1;
		if (j == 2) put(8'h00, 8'h01);
		put(8'h0D, 8'h01);
	endtask

	task automatic wait_out(input logic v);
		for (int i = 0; i < 120 && expiry !== v; i++) begin
			@(posedge clk);
			#1;
		end
	endtask

	task automatic results();
		if (mismatches == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		#100000;
		mismatches++;
		results();
	end

	initial begin
		{nrst, nrst_rtc, wr_en, rd_en, addr, wdata, seen2, seenr} = '0;
		ce = 1'b1;
		byte_acc = 1'b1;
		repeat (12) @(posedge clk);
		#1;
		nrst = 1'b1;
		nrst_rtc = 1'b1;
		`CHK("stage", ST_IDLE, stage)
		get(8'h15);
		get(8'h16);
		for (int i = 0; i < 4; i++) begin
			// Disable only right after a fresh load, far from timeout
			put(8'h18, tw[i]);
			get(8'h18);
			`CHK("lock", tw[i], d)
			`CHK("stage", ts[i], stage)
		end
		// Fast prescale and tiny preloads keep each stage near 33 cycles
		put(8'h10, 8'h04);
		foreach (pa[i]) unlock(pa[i], pv[i]);
		put(8'h18, 8'h02);
		seen2 = 1'b0;
		repeat (6) unlock(8'h0D, 8'h01);
		`CHK("kept", 1'b0, seen2)
		for (int j = 0; j < 3; j++) begin
			seen2 = 1'b0;
			repeat (j == 1 ? 7 : 5) bad_kick(j);
			`CHK("refused", 1'b1, seen2)
			unlock(8'h0D, 8'h01);
			`CHK("stage", ST_STAGE1, stage)
		end
		seenr = 1'b0;
		wait_out(1'b1);
		`CHK("pin", 1'b1, expiry)
		repeat (80) @(posedge clk);
		#1;
		`CHK("pin", 1'b1, expiry)
		`CHK("reset", 1'b1, seenr)
		put(8'h18, 8'h06);
		wait_out(1'b0);
		`CHK("pin", 1'b0, expiry)
		// Let the reset request pulse that follows the timeout drain first
		repeat (2) @(posedge clk);
		#1;
		ce = 1'b0;
		st = stage;
		seenr = 1'b0;
		repeat (70) @(posedge clk);
		#1;
		`CHK("frozen", st, stage)
		`CHK("reset", 1'b0, seenr)
		ce = 1'b1;
		put(8'h18, 8'h07);
		put(8'h18, 8'h00);
		get(8'h18);
		`CHK("lock", 8'h07, d)
		`CHK("run", 1'b1, stage !== ST_IDLE)
		nrst = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		nrst = 1'b1;
		get(8'h18);
		`CHK("lock", 8'h00, d)
		`CHK("pin", 1'b0, expiry)
		get(8'h0D);
		`CHK("flag", 8'h02, d)
		unlock(8'h0D, 8'h02);
		get(8'h0D);
		`CHK("flag", 8'h00, d)
		results();
	end
endmodule // test_wdt_core
